/* hdl/vapm_gprio.sv */
// Group priority of a virtual priority under the binary point settings.
// Assumes same-clock inputs; purely combinational.
module vapm_gprio
  import vapm_pkg::*;
(
  // Priority to reduce
  input wire logic [PRI_BITS-1:0] i_prio,
  input wire logic i_grp,
  // Binary point settings
  input wire logic i_cbpr,
  input wire logic [BP_W-1:0] i_bp0,
  input wire logic [BP_W-1:0] i_bp1,
  input wire logic i_secure,
  // Result
  output logic [PRI_BITS-1:0] o_gprio
);
  logic [3:0] shift;
  logic [PRI_BITS-1:0] mask;

  // Shift is point plus one; non-secure group 1 without CBPR uses one less, so a
  // zero point there yields a full mask rather than a negative shift
  always_comb begin
    if (!i_grp || i_cbpr) begin
      shift = {1'b0, i_bp0} + 4'h1;
    end else if (i_secure) begin
      shift = {1'b0, i_bp1} + 4'h1;
    end else begin
      shift = {1'b0, i_bp1};
    end
    mask = 8'hff << shift;
    o_gprio = i_prio & mask;
  end

endmodule : vapm_gprio

/* hdl/vapm_pkg.sv */
// Constants, register map and carrier types for the virtual active
// priority and maintenance block.
// Assumes one system clock and an AHB-Lite slave at a 256-byte window.
package vapm_pkg;

  // Sizes
  localparam int unsigned NUM_LR = 4;
  localparam int unsigned PRI_BITS = 8;
  localparam int unsigned PRE_BITS = 7;
  localparam int unsigned AP_BITS = 128;
  localparam int unsigned AP_REG_W = 32;
  localparam int unsigned AP_REGS_MAX = 4;
  localparam int unsigned NUM_AP_REGS =
    (PRE_BITS == 5) ? 1 : ((PRE_BITS == 6) ? 2 : 4);
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_AP0 = 8'h00;
  localparam logic [7:0] OFS_AP1 = 8'h10;
  localparam logic [7:0] OFS_HCR = 8'h20;
  localparam logic [7:0] OFS_VMCR = 8'h24;
  localparam logic [7:0] OFS_VTR = 8'h28;
  localparam logic [7:0] OFS_STAT = 8'h2c;
  localparam logic [7:0] OFS_GPRIO = 8'h30;
  localparam logic [7:0] AP_AREA_MASK = 8'hf0;

  // Hypervisor control fields
  localparam int unsigned HCR_EN = 0;
  localparam int unsigned HCR_UIE = 1;
  localparam int unsigned HCR_LRENPIE = 2;
  localparam int unsigned HCR_NPIE = 3;
  localparam int unsigned HCR_G0EIE = 4;
  localparam int unsigned HCR_G0DIE = 5;
  localparam int unsigned HCR_G1EIE = 6;
  localparam int unsigned HCR_G1DIE = 7;
  localparam int unsigned HCR_EOIIE = 8;
  localparam int unsigned HCR_CNT_LSB = 27;
  localparam int unsigned CNT_W = 5;
  localparam logic [31:0] HCR_WMASK = 32'h000001ff;
  localparam logic [31:0] HCR_RST = 32'h00000000;

  // Maintenance status fields
  localparam int unsigned ST_EOI = 0;
  localparam int unsigned ST_U = 1;
  localparam int unsigned ST_LRENP = 2;
  localparam int unsigned ST_NP = 3;
  localparam int unsigned ST_G0E = 4;
  localparam int unsigned ST_G0D = 5;
  localparam int unsigned ST_G1E = 6;
  localparam int unsigned ST_G1D = 7;
  localparam int unsigned ST_W = 8;

  // Virtual machine control fields
  localparam int unsigned VM_G0EN = 0;
  localparam int unsigned VM_G1EN = 1;
  localparam int unsigned VM_CBPR = 4;
  localparam int unsigned VM_BP0_LSB = 8;
  localparam int unsigned VM_BP1_LSB = 12;
  localparam int unsigned BP_W = 3;
  localparam logic [31:0] VMCR_WMASK = 32'h00007713;
  localparam logic [31:0] VMCR_RST = 32'h00000000;

  // Capability fields, each holding the count minus one
  localparam int unsigned VTR_PRE_LSB = 26;
  localparam int unsigned VTR_PRI_LSB = 29;
  localparam int unsigned VTR_FLD_W = 3;

  // Group priority probe fields
  localparam int unsigned GP_GRP = 8;
  localparam int unsigned GP_RES_LSB = 16;

  localparam logic [9:0] MAINT_INTID = 10'h019;

  typedef logic [AP_BITS-1:0] vapm_ap_t;

  typedef struct packed {
    logic grp;
    logic [PRI_BITS-1:0] prio;
  } vapm_ack_s;

  typedef struct packed {
    logic [NUM_LR-1:0] valid;
    logic [NUM_LR-1:0] pending;
    logic [NUM_LR-1:0] eoi;
  } vapm_lr_s;

endpackage : vapm_pkg

/* hdl/vapm_top.sv */
// Virtual active priority tracking and maintenance interrupt source.
// Assumes an AHB-Lite master on the system clock and CPU-side events
// (acknowledge, priority drop, EOI misses) from logic on that clock.
//
// Functional notes
// - Separate group 0 and group 1 active-priority vectors, four words each.
// - Eight-bit priority; bit zero ignored, so 128 active bits per group.
// - Implemented words follow preemption bits: 5->1, 6->2, 7->4.
// - Group 0 bit is one while an acknowledged interrupt awaits drop.
// - Group 1 bit is one while an acknowledged interrupt awaits drop.
// - List register updates never change either active-priority vector.
// - Maintenance interrupt asserts only in the cycle after global enable was one.
// - Maintenance interrupt is a level held while a condition lasts.
// - Enable bits request interrupts on group enabled or disabled.
// - Interrupt when no list register entry holds a pending interrupt.
// - Interrupt when an EOI arrives with no matching valid entry.
// - Underflow interrupt when zero or one entry is valid.
// - Interrupt while any list register entry has received an EOI.
// - Maintenance interrupt intended for physical identifier 25.
// - Group priority masks bits below the selected binary point.
// - Capability fields hold preemption and priority bit counts minus one.
// - Drop scans upward, group 0 before 1, changing only the first bit.
module vapm_top
  import vapm_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic I_HREADY,
  input wire logic [31:0] I_HWDATA,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // CPU interface events
  input wire logic I_ACK,
  input wire vapm_pkg::vapm_ack_s I_ACK_REQ,
  input wire logic I_DROP,
  input wire logic I_EOI_NO_LR,
  input wire logic I_SECURE,
  // List register state
  input wire vapm_pkg::vapm_lr_s I_LR,
  // Active priorities and maintenance interrupt
  output vapm_pkg::vapm_ap_t O_AP0,
  output vapm_pkg::vapm_ap_t O_AP1,
  output logic O_MAINT_IRQ,
  output logic [9:0] O_MAINT_INTID
);
  import vapm_pkg::*;

  logic ph_act_q;
  logic ph_wr_q;
  logic [ADDR_W-1:0] addr_q;
  logic wr_en;
  vapm_ap_t ap0_q;
  vapm_ap_t ap1_q;
  vapm_ap_t ap0_w;
  vapm_ap_t ap1_w;
  vapm_ap_t ap0_d;
  vapm_ap_t ap1_d;
  vapm_ap_t impl_mask;
  logic [2*AP_BITS-1:0] scan_vec;
  logic drop_found;
  logic [7:0] drop_pos;
  logic [31:0] hcr_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [31:0] vmcr_q;
  logic [8:0] gp_q;
  logic [PRI_BITS-1:0] gp_res;
  logic [ST_W-1:0] live;
  logic [ST_W-1:0] stat;
  logic [ST_W-1:0] stat_en;
  logic maint_q;
  logic [31:0] vtr;
  logic [6:0] ack_idx;

  // Address match of one register word
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : hit

  // Upward scan over interleaved bits, group 0 first at each position
  function automatic logic [8:0] first_set(input logic [2*AP_BITS-1:0] v);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 2 * AP_BITS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 8'(i)};
      end
    end
    return r;
  endfunction : first_set

  // Zero wait states; every access completes OKAY
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_MAINT_INTID = MAINT_INTID;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ph_act_q <= 1'b0;
      ph_wr_q <= 1'b0;
      addr_q <= '0;
    end else begin
      ph_act_q <= I_HSEL & I_HTRANS[1] & I_HREADY;
      ph_wr_q <= I_HSEL & I_HTRANS[1] & I_HREADY & I_HWRITE;
      if (I_HSEL & I_HTRANS[1] & I_HREADY) begin
        addr_q <= I_HADDR[ADDR_W-1:0];
      end
    end
  end

  assign wr_en = ph_wr_q;

  // Software writes merge first, hardware events apply on top of them
  genvar g;
  generate
    for (g = 0; g < AP_REGS_MAX; g++) begin : g_ap
      localparam logic [ADDR_W-1:0] A0 = ADDR_W'(OFS_AP0 + 4 * g);
      localparam logic [ADDR_W-1:0] A1 = ADDR_W'(OFS_AP1 + 4 * g);
      localparam logic IMPL = (g < NUM_AP_REGS);
      assign impl_mask[g*AP_REG_W +: AP_REG_W] = {AP_REG_W{IMPL}};
      always_comb begin
        ap0_w[g*AP_REG_W +: AP_REG_W] = ap0_q[g*AP_REG_W +: AP_REG_W];
        ap1_w[g*AP_REG_W +: AP_REG_W] = ap1_q[g*AP_REG_W +: AP_REG_W];
        if (wr_en && IMPL && hit(addr_q, A0)) begin
          ap0_w[g*AP_REG_W +: AP_REG_W] = I_HWDATA;
        end
        if (wr_en && IMPL && hit(addr_q, A1)) begin
          ap1_w[g*AP_REG_W +: AP_REG_W] = I_HWDATA;
        end
      end
    end
    for (g = 0; g < AP_BITS; g++) begin : g_scan
      assign scan_vec[2*g] = ap0_w[g];
      assign scan_vec[2*g+1] = ap1_w[g];
    end
  endgenerate

  assign {drop_found, drop_pos} = first_set(scan_vec);
  assign ack_idx = I_ACK_REQ.prio[PRI_BITS-1:1];

  // Only acknowledge, drop and bus writes touch the vectors; list
  // register traffic has no path in here
  always_comb begin
    ap0_d = ap0_w;
    ap1_d = ap1_w;
    if (I_DROP && drop_found) begin
      if (drop_pos[0]) begin
        ap1_d[drop_pos[7:1]] = 1'b0;
      end else begin
        ap0_d[drop_pos[7:1]] = 1'b0;
      end
    end
    if (I_ACK) begin
      if (I_ACK_REQ.grp) begin
        ap1_d[ack_idx] = 1'b1;
      end else begin
        ap0_d[ack_idx] = 1'b1;
      end
    end
    ap0_d = ap0_d & impl_mask;
    ap1_d = ap1_d & impl_mask;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ap0_q <= '0;
      ap1_q <= '0;
    end else begin
      ap0_q <= ap0_d;
      ap1_q <= ap1_d;
    end
  end

  assign O_AP0 = ap0_q;
  assign O_AP1 = ap1_q;

  // EOI miss counter: an event in the write cycle still counts
  always_comb begin
    cnt_d = cnt_q;
    if (wr_en && hit(addr_q, OFS_HCR)) begin
      cnt_d = I_HWDATA[HCR_CNT_LSB +: CNT_W];
    end
    if (I_EOI_NO_LR && cnt_d != {CNT_W{1'b1}}) begin
      cnt_d = cnt_d + 5'h01;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hcr_q <= HCR_RST;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (wr_en && hit(addr_q, OFS_HCR)) begin
        hcr_q <= I_HWDATA & HCR_WMASK;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      vmcr_q <= VMCR_RST;
      gp_q <= '0;
    end else begin
      if (wr_en && hit(addr_q, OFS_VMCR)) begin
        vmcr_q <= I_HWDATA & VMCR_WMASK;
      end
      if (wr_en && hit(addr_q, OFS_GPRIO)) begin
        gp_q <= I_HWDATA[8:0];
      end
    end
  end

  vapm_gprio u_gprio (
    .i_prio(gp_q[PRI_BITS-1:0]),
    .i_grp(gp_q[GP_GRP]),
    .i_cbpr(vmcr_q[VM_CBPR]),
    .i_bp0(vmcr_q[VM_BP0_LSB +: BP_W]),
    .i_bp1(vmcr_q[VM_BP1_LSB +: BP_W]),
    .i_secure(I_SECURE),
    .o_gprio(gp_res)
  );

  // Live conditions and their enables, bit for bit
  always_comb begin
    live = '0;
    live[ST_EOI] = |I_LR.eoi;
    live[ST_U] = $countones(I_LR.valid) <= 1;
    live[ST_LRENP] = cnt_q != '0;
    live[ST_NP] = ~|(I_LR.valid & I_LR.pending);
    live[ST_G0E] = vmcr_q[VM_G0EN];
    live[ST_G0D] = ~vmcr_q[VM_G0EN];
    live[ST_G1E] = vmcr_q[VM_G1EN];
    live[ST_G1D] = ~vmcr_q[VM_G1EN];
    stat_en = '0;
    stat_en[ST_EOI] = hcr_q[HCR_EOIIE];
    stat_en[ST_U] = hcr_q[HCR_UIE];
    stat_en[ST_LRENP] = hcr_q[HCR_LRENPIE];
    stat_en[ST_NP] = hcr_q[HCR_NPIE];
    stat_en[ST_G0E] = hcr_q[HCR_G0EIE];
    stat_en[ST_G0D] = hcr_q[HCR_G0DIE];
    stat_en[ST_G1E] = hcr_q[HCR_G1EIE];
    stat_en[ST_G1D] = hcr_q[HCR_G1DIE];
    stat = live & stat_en;
  end

  // Registered level so the output is glitch free; it follows the
  // condition with one cycle of lag
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      maint_q <= 1'b0;
    end else begin
      maint_q <= hcr_q[HCR_EN] & (|stat);
    end
  end

  assign O_MAINT_IRQ = maint_q;

  always_comb begin
    vtr = '0;
    vtr[VTR_PRE_LSB +: VTR_FLD_W] = 3'(PRE_BITS - 1);
    vtr[VTR_PRI_LSB +: VTR_FLD_W] = 3'(PRI_BITS - 1);
  end

  // Read data comes from the registers through the data-phase decode
  always_comb begin
    O_HRDATA = 32'h00000000;
    if (ph_act_q && !ph_wr_q) begin
      if ((addr_q & AP_AREA_MASK) == OFS_AP0) begin
        O_HRDATA = ap0_q[{addr_q[3:2], 5'h00} +: AP_REG_W];
      end else if ((addr_q & AP_AREA_MASK) == OFS_AP1) begin
        O_HRDATA = ap1_q[{addr_q[3:2], 5'h00} +: AP_REG_W];
      end else if (hit(addr_q, OFS_HCR)) begin
        O_HRDATA = hcr_q;
        O_HRDATA[HCR_CNT_LSB +: CNT_W] = cnt_q;
      end else if (hit(addr_q, OFS_VMCR)) begin
        O_HRDATA = vmcr_q;
      end else if (hit(addr_q, OFS_VTR)) begin
        O_HRDATA = vtr;
      end else if (hit(addr_q, OFS_STAT)) begin
        O_HRDATA = {24'h000000, stat};
      end else if (hit(addr_q, OFS_GPRIO)) begin
        O_HRDATA = {8'h00, gp_res, 7'h00, gp_q};
      end
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  property p_maint_en;
    O_MAINT_IRQ |-> $past(hcr_q[HCR_EN]);
  endproperty
  a_maint_en: assert property (p_maint_en)
    else $error("maintenance irq without global enable");

  property p_maint_level;
    (hcr_q[HCR_EN] && (|stat)) [*2] |=> O_MAINT_IRQ;
  endproperty
  a_maint_level: assert property (p_maint_level)
    else $error("maintenance irq dropped while condition held");

  property p_ack0;
    (I_ACK && !I_ACK_REQ.grp && !I_DROP) |=> ap0_q[$past(ack_idx)];
  endproperty
  a_ack0: assert property (p_ack0)
    else $error("group 0 active bit not set on acknowledge");

  property p_ack1;
    (I_ACK && I_ACK_REQ.grp && !I_DROP) |=> ap1_q[$past(ack_idx)];
  endproperty
  a_ack1: assert property (p_ack1)
    else $error("group 1 active bit not set on acknowledge");

  property p_drop_one;
    (I_DROP && !I_ACK && !wr_en && (|{ap0_q, ap1_q})) |=>
      $countones({ap0_q, ap1_q}) == $countones($past({ap0_q, ap1_q})) - 1;
  endproperty
  a_drop_one: assert property (p_drop_one)
    else $error("priority drop did not clear exactly one bit");

  property p_lr_quiet;
    (!I_ACK && !I_DROP && !wr_en) |=> $stable({ap0_q, ap1_q});
  endproperty
  a_lr_quiet: assert property (p_lr_quiet)
    else $error("active priorities changed without cause");

  property p_underflow;
    hcr_q[HCR_UIE] && ($countones(I_LR.valid) <= 1) |-> stat[ST_U];
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow status missing");

  property p_no_pend;
    hcr_q[HCR_NPIE] && !(|(I_LR.valid & I_LR.pending)) |-> stat[ST_NP];
  endproperty
  a_no_pend: assert property (p_no_pend)
    else $error("no-pending status missing");

  property p_eoi_miss;
    (I_EOI_NO_LR && hcr_q[HCR_LRENPIE] && !wr_en) |=> stat[ST_LRENP];
  endproperty
  a_eoi_miss: assert property (p_eoi_miss)
    else $error("EOI miss did not raise status");

  property p_lr_eoi;
    hcr_q[HCR_EOIIE] && (|I_LR.eoi) |-> stat[ST_EOI];
  endproperty
  a_lr_eoi: assert property (p_lr_eoi)
    else $error("list register EOI status missing");

  property p_grp_dis;
    hcr_q[HCR_G1DIE] && !vmcr_q[VM_G1EN] |-> stat[ST_G1D] && !stat[ST_G1E];
  endproperty
  a_grp_dis: assert property (p_grp_dis)
    else $error("group 1 disabled status wrong");

endmodule : vapm_top

/* sim/vapm_pe_model.sv */
// Processor-side model: acknowledge, drop and EOI-miss pulses, plus the
// list register and security levels that it presents to the block.
// Assumes the block takes each pulse on the rising edge after it rises.
module vapm_pe_model
  import vapm_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Event pulses
  output logic o_ack,
  output vapm_pkg::vapm_ack_s o_ack_req,
  output logic o_drop,
  output logic o_eoi_no_lr,
  // Levels
  output logic o_secure,
  output vapm_pkg::vapm_lr_s o_lr
);
  timeunit 1ns;
  timeprecision 1ns;
  import vapm_pkg::*;

  // Idle cycles before each acknowledge and drop pulse, so those events come promptly or late
  int gap = 0;

  initial begin
    o_ack = 1'b0;
    o_ack_req = '0;
    o_drop = 1'b0;
    o_eoi_no_lr = 1'b0;
    o_secure = 1'b0;
    o_lr = '0;
  end

  task automatic ack(input logic g, input logic [7:0] p);
    repeat (gap) @(posedge i_clk);
    o_ack <= 1'b1;
    o_ack_req <= '{grp: g, prio: p};
    @(posedge i_clk);
    o_ack <= 1'b0;
    // A stale qualifier must not look like a fresh request
    o_ack_req <= ~o_ack_req;
  endtask : ack

  task automatic drop();
    repeat (gap) @(posedge i_clk);
    o_drop <= 1'b1;
    @(posedge i_clk);
    o_drop <= 1'b0;
  endtask : drop

  task automatic eoi_miss();
    o_eoi_no_lr <= 1'b1;
    @(posedge i_clk);
    o_eoi_no_lr <= 1'b0;
  endtask : eoi_miss

  task automatic set_ctx(input vapm_lr_s l, input logic s);
    o_lr <= l;
    o_secure <= s;
  endtask : set_ctx

endmodule : vapm_pe_model

/* sim/vapm_tb_top.sv */
// Self-checking bench for the active priority and maintenance block.
// Assumes an AHB-Lite master of single word transfers and the PE model.
module vapm_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import vapm_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic ack;
  logic drop;
  logic eoi_miss;
  logic secure;
  vapm_ack_s ack_req;
  vapm_lr_s lr;
  vapm_lr_s l;
  vapm_ap_t ap0, ap1, e0, e1;
  logic irq;
  logic [9:0] intid;
  logic [31:0] rv, h, vm;
  logic [31:0] s0 [4];
  logic [31:0] s1 [4];
  logic [7:0] p, s;
  logic g, sec;
  int miscompares = 0;
  int num_checks = 0;

  always #50 clk = ~clk;

  vapm_top DUT (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HREADY(hready), .I_HWDATA(hwdata), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_ACK(ack), .I_ACK_REQ(ack_req),
    .I_DROP(drop), .I_EOI_NO_LR(eoi_miss), .I_SECURE(secure),
    .I_LR(lr), .O_AP0(ap0), .O_AP1(ap1), .O_MAINT_IRQ(irq),
    .O_MAINT_INTID(intid)
  );

  vapm_pe_model pe (
    .i_clk(clk), .o_ack(ack), .o_ack_req(ack_req), .o_drop(drop),
    .o_eoi_no_lr(eoi_miss), .o_secure(secure), .o_lr(lr)
  );

  task automatic results();
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [127:0] ex,
                       input logic [127:0] got);
    num_checks++;
    if (got !== ex) begin
      $display("BAD %s exp %h got %h", nm, ex, got);
      miscompares++;
    end
  endtask : check

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      miscompares++;
      results();
    end
  endtask : wait_rdy

  // Entered just after a rising edge; returns at the edge ending the data
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check("hresp", '0, 128'(hresp));
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  function automatic logic [7:0] exp_stat(logic [31:0] hc, logic [31:0] v,
                                          vapm_lr_s q);
    logic [7:0] t;
    t[ST_EOI] = (|q.eoi) & hc[HCR_EOIIE];
    t[ST_U] = ($countones(q.valid) <= 1) & hc[HCR_UIE];
    t[ST_LRENP] = (hc[31:27] != 5'h0) & hc[HCR_LRENPIE];
    t[ST_NP] = ((q.valid & q.pending) == '0) & hc[HCR_NPIE];
    t[ST_G0E] = v[VM_G0EN] & hc[HCR_G0EIE];
    t[ST_G0D] = !v[VM_G0EN] & hc[HCR_G0DIE];
    t[ST_G1E] = v[VM_G1EN] & hc[HCR_G1EIE];
    t[ST_G1D] = !v[VM_G1EN] & hc[HCR_G1DIE];
    return t;
  endfunction : exp_stat

  function automatic logic [7:0] exp_gp(logic [7:0] pr, logic gr,
                                        logic [31:0] v, logic sc);
    int sh;
    if (!gr || v[VM_CBPR]) begin
      sh = v[VM_BP0_LSB +: 3] + 1;
    end else if (sc) begin
      sh = v[VM_BP1_LSB +: 3] + 1;
    end else begin
      sh = v[VM_BP1_LSB +: 3];
    end
    return pr & (8'hff << sh);
  endfunction : exp_gp

  function automatic void scan_drop(inout vapm_ap_t a0, inout vapm_ap_t a1);
    for (int i = 0; i < AP_BITS; i++) begin
      if (a0[i]) begin
        a0[i] = 1'b0;
        return;
      end else if (a1[i]) begin
        a1[i] = 1'b0;
        return;
      end
    end
  endfunction : scan_drop

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(61));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("intid", 128'(10'd25), 128'(intid));
    bus(1'b0, OFS_VTR, '0, rv);
    check("vtr", {3'(PRI_BITS-1), 3'(PRE_BITS-1), 26'h0}, 128'(rv));
    bus(1'b0, 8'h40, '0, rv);
    check("unmapped", '0, 128'(rv));
    e0 = '0;
    e1 = '0;
    for (int k = 0; k < 24; k++) begin
      g = 1'(k) ^ 1'($urandom);
      p = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      if ((g && e0[p[7:1]]) || (!g && e1[p[7:1]])) g = !g;
      pe.gap = k % 3;
      pe.ack(g, p);
      if (g) e1[p[7:1]] = 1'b1;
      else e0[p[7:1]] = 1'b1;
      @(posedge clk);
      check("ap0", e0, ap0);
      check("ap1", e1, ap1);
    end
    pe.set_ctx(12'($urandom), 1'b0);
    repeat (2) @(posedge clk);
    check("ap0_lr", e0, ap0);
    check("ap1_lr", e1, ap1);
    // Save, clear, then restore as a context switch would
    for (int w = 0; w < NUM_AP_REGS; w++) begin
      bus(1'b0, 8'(OFS_AP0 + 4*w), '0, s0[w]);
      bus(1'b0, 8'(OFS_AP1 + 4*w), '0, s1[w]);
      check("ap0_word", 128'(e0[32*w +: 32]), 128'(s0[w]));
      check("ap1_word", 128'(e1[32*w +: 32]), 128'(s1[w]));
      wr(8'(OFS_AP0 + 4*w), '0);
      wr(8'(OFS_AP1 + 4*w), '0);
    end
    @(posedge clk);
    check("ap_clr", '0, ap0 | ap1);
    for (int w = 0; w < NUM_AP_REGS; w++) wr(8'(OFS_AP0 + 4*w), s0[w]);
    for (int w = 0; w < NUM_AP_REGS; w++) wr(8'(OFS_AP1 + 4*w), s1[w]);
    @(posedge clk);
    check("ap0_rest", e0, ap0);
    check("ap1_rest", e1, ap1);
    // Drop and acknowledge together: the drop sees the vectors before
    // the acknowledge sets its bit
    pe.gap = 0;
    g = !e0[1];
    fork
      pe.ack(g, 8'h02);
      pe.drop();
    join
    scan_drop(e0, e1);
    if (g) e1[1] = 1'b1;
    else e0[1] = 1'b1;
    @(posedge clk);
    check("ap0_both", e0, ap0);
    check("ap1_both", e1, ap1);
    // Drops clear the lowest set bit in turn; the last ones find nothing set and must be ignored
    for (int k = 0; k < 26; k++) begin
      pe.drop();
      scan_drop(e0, e1);
      @(posedge clk);
      check("ap0_drop", e0, ap0);
      check("ap1_drop", e1, ap1);
    end
    l = '{valid: 4'hf, pending: 4'h1, eoi: 4'h0};
    pe.set_ctx(l, 1'b0);
    wr(OFS_HCR, 32'h5);
    repeat (2) @(posedge clk);
    check("irq_nomiss", '0, 128'(irq));
    pe.eoi_miss();
    repeat (2) @(posedge clk);
    bus(1'b0, OFS_STAT, '0, rv);
    check("stat_miss", 128'(8'h04), 128'(rv[7:0]));
    check("irq_miss", 128'(1'b1), 128'(irq));
    // A miss in the cycle that writes the count adds on top of it
    fork
      wr(OFS_HCR, 32'h18000005);
      begin
        @(posedge clk);
        pe.eoi_miss();
      end
    join
    bus(1'b0, OFS_HCR, '0, rv);
    check("eoi_cnt", 128'(5'h04), 128'(rv[HCR_CNT_LSB +: CNT_W]));
    for (int k = 0; k < 40; k++) begin
      h = $urandom & (HCR_WMASK | 32'hf8000000);
      if (k < 16) h = 32'(k % 2) | (32'h1 << (k/2 + 1));
      vm = $urandom & VMCR_WMASK;
      l = 12'($urandom);
      pe.set_ctx(l, 1'($urandom));
      wr(OFS_VMCR, vm);
      wr(OFS_HCR, h);
      repeat (2) @(posedge clk);
      bus(1'b0, OFS_STAT, '0, rv);
      s = exp_stat(h, vm, l);
      check("stat", 128'(s), 128'(rv[7:0]));
      check("irq", 128'(h[0] & (|s)), 128'(irq));
    end
    for (int k = 0; k < 24; k++) begin
      vm = (k == 0) ? 32'h0 : ($urandom & VMCR_WMASK);
      p = 8'($urandom);
      g = (k == 0) ? 1'b1 : 1'($urandom);
      sec = (k == 0) ? 1'b0 : 1'($urandom);
      pe.set_ctx(l, sec);
      wr(OFS_VMCR, vm);
      wr(OFS_GPRIO, {23'h0, g, p});
      bus(1'b0, OFS_GPRIO, '0, rv);
      check("gprio", 128'(exp_gp(p, g, vm, sec)), 128'(rv[23:16]));
      check("gp_back", 128'({g, p}), 128'(rv[8:0]));
    end
    results();
  end

endmodule : vapm_tb_top
